// [common/flag_port_params.svh]
// constants for the semaphore port controller: widths and pin timing
`ifndef FLAG_PORT_PARAMS_SVH
`define FLAG_PORT_PARAMS_SVH

// ========================================
// widths
`define FP_FLAG_COUNT 8
`define FP_INDEX_W 3
`define FP_ADDR_W 16
`define FP_DATA_W 9
`define FP_LAST_INDEX 3'h7

// ========================================
// pin timing, in ns, and derived mclk counts (least times round up)
`define FP_MCLK_NS 20
`define FP_SETUP_NS 20
`define FP_STROBE_NS 30
`define FP_RECOVER_NS 20
`define FP_SYNC_STAGES 2
`define FP_SETUP_CYC \
  ((`FP_SETUP_NS + `FP_MCLK_NS - 1) / `FP_MCLK_NS)
`define FP_STROBE_CYC \
  ((`FP_STROBE_NS + `FP_MCLK_NS - 1) / `FP_MCLK_NS)
`define FP_RECOVER_CYC \
  ((`FP_RECOVER_NS + `FP_MCLK_NS - 1) / `FP_MCLK_NS)

// ========================================
// acquire polling
`define FP_POLL_LIMIT 8'h10

`endif

// [common/flag_port_pkg.sv]
// types shared by the semaphore port controller
package flag_port_pkg;

  // ========================================
  // pin group toward one port of the shared ram
  typedef struct packed {
    logic flag_space_select_n;
    logic array_en_n;
    logic rw_n;
    logic out_en_n;
    logic [15:0] addr;
    logic [8:0] dq_out;
    logic dq_oe;
  } port_pins_s;

  // ========================================
  // user commands and replies
  typedef enum logic [1:0] {
    OP_INIT = 2'h0,
    OP_ACQUIRE = 2'h1,
    OP_RELEASE = 2'h2,
    OP_READ = 2'h3
  } flag_op_e;

  typedef struct packed {
    flag_op_e op;
    logic [2:0] flag_index_lines;
  } flag_cmd_s;

  typedef struct packed {
    flag_op_e op;
    logic [2:0] flag_index_lines;
    logic flag_value;
    logic granted;
  } flag_resp_s;

endpackage

// [hdl/flag_bus_cycle.sv]
// one semaphore read or write cycle on the port pins
`timescale 1ns/1ps
`include "flag_port_params.svh"

module flag_bus_cycle (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // cycle request
  input wire logic start,
  input wire logic is_write,
  input wire logic wbit,
  input wire logic [2:0] flag_index_lines,
  output logic busy,
  output logic done,
  output logic rbit,
  // port pins
  output flag_port_pkg::port_pins_s pins,
  input wire logic [8:0] dq_in
);
  import flag_port_pkg::*;

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_SETUP = 4'h2,
    C_STROBE = 4'h4,
    C_RECOVER = 4'h8
  } cyc_state_e;

  cyc_state_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next;
  logic done_reg, done_next;
  logic rbit_reg, rbit_next;
  port_pins_s pins_reg, pins_next;
  logic [8:0] dq_meta_reg, dq_sync_reg;

  // ========================================
  // pin input synchroniser
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_meta_reg <= 9'h000;
      dq_sync_reg <= 9'h000;
    end else begin
      dq_meta_reg <= dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // ========================================
  // cycle sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    done_next = 1'b0;
    rbit_next = rbit_reg;
    pins_next = pins_reg;
    case (state_reg)
      C_IDLE: begin
        if (start) begin
          wr_next = is_write;
          pins_next.flag_space_select_n = 1'b0;
          pins_next.array_en_n = 1'b1;
          pins_next.addr = {13'h0000, flag_index_lines};
          cnt_next = 4'(`FP_SETUP_CYC - 1);
          state_next = C_SETUP;
        end
      end
      C_SETUP: begin
        if (cnt_reg == 4'h0) begin
          if (wr_reg) begin
            pins_next.rw_n = 1'b0;
            pins_next.dq_out = {8'h00, wbit};
            pins_next.dq_oe = 1'b1;
            cnt_next = 4'(`FP_STROBE_CYC - 1);
          end else begin
            pins_next.out_en_n = 1'b0;
            // extra cycles let the returned level cross the synchroniser
            cnt_next = 4'(`FP_STROBE_CYC + `FP_SYNC_STAGES - 1);
          end
          state_next = C_STROBE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      C_STROBE: begin
        if (cnt_reg == 4'h0) begin
          if (!wr_reg) begin
            rbit_next = dq_sync_reg[0];
          end
          // select and strobes go inactive every cycle, so polled
          // reads see a fresh latch value
          pins_next.rw_n = 1'b1;
          pins_next.out_en_n = 1'b1;
          pins_next.flag_space_select_n = 1'b1;
          cnt_next = 4'(`FP_RECOVER_CYC - 1);
          state_next = C_RECOVER;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      C_RECOVER: begin
        if (cnt_reg == 4'h0) begin
          pins_next.dq_oe = 1'b0;
          pins_next.dq_out = 9'h000;
          done_next = 1'b1;
          state_next = C_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: begin
        state_next = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= C_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      done_reg <= 1'b0;
      rbit_reg <= 1'b1;
      pins_reg <= '{flag_space_select_n: 1'b1, array_en_n: 1'b1,
                    rw_n: 1'b1, out_en_n: 1'b1, addr: 16'h0000,
                    dq_out: 9'h000, dq_oe: 1'b0};
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      done_reg <= done_next;
      rbit_reg <= rbit_next;
      pins_reg <= pins_next;
    end
  end

  assign busy = (state_reg != C_IDLE);
  assign done = done_reg;
  assign rbit = rbit_reg;
  assign pins = pins_reg;

endmodule // flag_bus_cycle

// [hdl/flag_port_ctrl.sv]
// controller for one port of the shared-ram semaphore flags
`timescale 1ns/1ps
`include "flag_port_params.svh"

// What this block does
// - write zero requests, one releases
// - drop select between polling reads
// - write zero first, then read to confirm
// - failed request: keep reading or withdraw
// - software frees every flag at start
// - array enable high during flag access
module flag_port_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // command side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input flag_port_pkg::flag_cmd_s cmd,
  output logic resp_valid,
  output flag_port_pkg::flag_resp_s resp,
  output logic init_done,
  // port pins
  output flag_port_pkg::port_pins_s pins,
  input wire logic [8:0] dq_in
);
  import flag_port_pkg::*;

  typedef enum logic [7:0] {
    M_INIT = 8'h01,
    M_IDLE = 8'h02,
    M_ACQ_W = 8'h04,
    M_ACQ_R = 8'h08,
    M_WDRAW = 8'h10,
    M_REL_W = 8'h20,
    M_READ = 8'h40,
    M_REPLY = 8'h80
  } main_state_e;

  main_state_e state_reg, state_next;
  logic launched_reg, launched_next;
  logic [2:0] idx_reg, idx_next;
  flag_op_e op_reg, op_next;
  logic [7:0] poll_reg, poll_next;
  logic flag_reg, flag_next;
  logic granted_reg, granted_next;
  logic init_done_reg, init_done_next;
  logic cyc_start, cyc_write, cyc_wbit;
  logic cyc_busy, cyc_done, cyc_rbit;

  // ========================================
  // pin cycle engine
  flag_bus_cycle u_cycle (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(cyc_start),
    .is_write(cyc_write),
    .wbit(cyc_wbit),
    .flag_index_lines(idx_reg),
    .busy(cyc_busy),
    .done(cyc_done),
    .rbit(cyc_rbit),
    .pins(pins),
    .dq_in(dq_in)
  );

  // ========================================
  // which cycle each state runs
  always_comb begin
    cyc_write = 1'b1;
    cyc_wbit = 1'b1;
    case (state_reg)
      M_ACQ_W: cyc_wbit = 1'b0;
      M_ACQ_R: cyc_write = 1'b0;
      M_READ: cyc_write = 1'b0;
      default: cyc_wbit = 1'b1;
    endcase
  end

  assign cyc_start = !launched_reg && !cyc_busy &&
                     (state_reg != M_IDLE) && (state_reg != M_REPLY);

  // ========================================
  // operation sequencer
  always_comb begin
    state_next = state_reg;
    launched_next = launched_reg;
    idx_next = idx_reg;
    op_next = op_reg;
    poll_next = poll_reg;
    flag_next = flag_reg;
    granted_next = granted_reg;
    init_done_next = init_done_reg;
    if (cyc_start) begin
      launched_next = 1'b1;
    end
    if (cyc_done) begin
      launched_next = 1'b0;
    end
    case (state_reg)
      M_INIT: begin
        // ones to all eight flags free any stale request latch
        if (cyc_done) begin
          if (idx_reg == `FP_LAST_INDEX) begin
            init_done_next = 1'b1;
            flag_next = 1'b1;
            granted_next = 1'b0;
            state_next = M_REPLY;
          end else begin
            idx_next = idx_reg + 3'h1;
          end
        end
      end
      M_IDLE: begin
        if (cmd_valid) begin
          op_next = cmd.op;
          idx_next = cmd.flag_index_lines;
          poll_next = 8'h00;
          granted_next = 1'b0;
          case (cmd.op)
            OP_INIT: begin
              idx_next = 3'h0;
              init_done_next = 1'b0;
              state_next = M_INIT;
            end
            OP_ACQUIRE: state_next = M_ACQ_W;
            OP_RELEASE: state_next = M_REL_W;
            OP_READ: state_next = M_READ;
            default: state_next = M_IDLE;
          endcase
        end
      end
      M_ACQ_W: begin
        if (cyc_done) begin
          state_next = M_ACQ_R;
        end
      end
      M_ACQ_R: begin
        if (cyc_done) begin
          flag_next = cyc_rbit;
          if (!cyc_rbit) begin
            granted_next = 1'b1;
            state_next = M_REPLY;
          end else if (poll_reg == `FP_POLL_LIMIT - 8'h01) begin
            // give up rather than leave a request pending forever
            state_next = M_WDRAW;
          end else begin
            poll_next = poll_reg + 8'h01;
          end
        end
      end
      M_WDRAW: begin
        if (cyc_done) begin
          state_next = M_REPLY;
        end
      end
      M_REL_W: begin
        if (cyc_done) begin
          flag_next = 1'b1;
          state_next = M_REPLY;
        end
      end
      M_READ: begin
        if (cyc_done) begin
          flag_next = cyc_rbit;
          state_next = M_REPLY;
        end
      end
      M_REPLY: begin
        state_next = M_IDLE;
      end
      default: begin
        state_next = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= M_INIT;
      launched_reg <= 1'b0;
      idx_reg <= 3'h0;
      op_reg <= OP_INIT;
      poll_reg <= 8'h00;
      flag_reg <= 1'b1;
      granted_reg <= 1'b0;
      init_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      launched_reg <= launched_next;
      idx_reg <= idx_next;
      op_reg <= op_next;
      poll_reg <= poll_next;
      flag_reg <= flag_next;
      granted_reg <= granted_next;
      init_done_reg <= init_done_next;
    end
  end

  // ========================================
  // command and reply outputs
  assign cmd_ready = (state_reg == M_IDLE);
  assign resp_valid = (state_reg == M_REPLY);
  assign resp = '{op: op_reg, flag_index_lines: idx_reg,
                  flag_value: flag_reg, granted: granted_reg};
  assign init_done = init_done_reg;

endmodule // flag_port_ctrl

// [dv/flag_ram_model.sv]
// behavioural semaphore side of the shared ram, right port as a stub
`timescale 1ns/1ps
module flag_ram_model (
  // left port pins
  input flag_port_pkg::port_pins_s pins,
  output logic [8:0] dq_in,
  // right port stub
  input wire logic r_we,
  input wire logic [2:0] r_idx,
  input wire logic r_bit,
  output logic [7:0] r_flag
);
  import flag_port_pkg::*;
  // ====
  // state: 1 in req means a zero is latched
  // power-up content deliberately messy
  logic [7:0] req_l = 8'hC3, req_r = 8'h3C, own_l = 8'h00, own_r = 8'h00;
  logic wr_on = 1'b0, rd_on = 1'b0, w_bit;
  logic [2:0] w_idx;
  logic [8:0] rd_val = 9'h000;
  task automatic settle(input int i);
    if (!own_l[i] && !own_r[i]) begin
      own_l[i] = req_l[i];
      own_r[i] = req_r[i] && !req_l[i];
    end
    if (own_l[i] && !req_l[i]) begin
      own_l[i] = 1'b0;
      own_r[i] = req_r[i];
    end
    if (own_r[i] && !req_r[i]) begin
      own_r[i] = 1'b0;
      own_l[i] = req_l[i];
    end
  endtask
  initial begin
    for (int i = 0; i < 8; i++) settle(i);
  end
  // ====
  // left port: write lands when the strobe ends, no wait state
  always @(pins) begin
    if (!pins.flag_space_select_n && !pins.rw_n) begin
      wr_on = 1'b1;
      w_idx = pins.addr[2:0];
      w_bit = pins.dq_out[0];
    end else if (wr_on) begin
      wr_on = 1'b0;
      req_l[w_idx] = !w_bit;
      settle(w_idx);
    end
    if (!pins.flag_space_select_n && !pins.out_en_n) begin
      if (!rd_on) begin
        rd_val = {9{!own_l[pins.addr[2:0]]}};
      end
      rd_on = 1'b1;
    end else begin // deselected or standby
      rd_on = 1'b0;
    end
  end
  // released bus shows the inverse, never a stale copy
  assign dq_in = rd_on ? rd_val : ~rd_val;
  // ====
  // right port, independent of the left
  always @(posedge r_we) begin
    req_r[r_idx] = !r_bit;
    settle(r_idx);
  end
  assign r_flag = ~own_r;
endmodule // flag_ram_model

// [dv/flag_port_ctrl_props.sv]
// concurrent checks on the semaphore port controller
`timescale 1ns/1ps
module flag_port_ctrl_props (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // command side
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input flag_port_pkg::flag_cmd_s cmd,
  input wire logic resp_valid,
  input flag_port_pkg::flag_resp_s resp,
  input wire logic init_done,
  // port pins
  input flag_port_pkg::port_pins_s pins,
  input wire logic [8:0] dq_in
);
  import flag_port_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ====
  sequence s_take(flag_op_e o);
    cmd_valid && cmd_ready && cmd.op == o;
  endsequence
  sequence s_wr(logic b);
    !pins.flag_space_select_n && !pins.rw_n && pins.dq_out[0] == b;
  endsequence
  property p_array_off;
    pins.array_en_n;
  endproperty
  property p_write_first;
    s_take(OP_ACQUIRE) |-> pins.out_en_n throughout (##[1:8] s_wr(1'b0));
  endproperty
  property p_release_one;
    s_take(OP_RELEASE) |-> ##[1:8] s_wr(1'b1);
  endproperty
  property p_poll_gap;
    $rose(pins.out_en_n) |-> pins.flag_space_select_n;
  endproperty
  property p_clean_bits;
    pins.dq_oe |-> pins.addr[15:3] == 13'h0000 && pins.dq_out[8:1] == 8'h00;
  endproperty
  property p_no_clash;
    !pins.out_en_n |-> pins.rw_n && !pins.dq_oe && !pins.flag_space_select_n;
  endproperty
  property p_init;
    $fell(sys_rst) |-> ##[1:200] init_done;
  endproperty
  property p_read_len;
    $fell(pins.out_en_n) |-> (!pins.out_en_n)[*4] ##1 pins.out_en_n;
  endproperty
  property p_reinit;
    s_take(OP_INIT) |=> !init_done ##[1:200] init_done;
  endproperty
  property p_confirm;
    $fell(pins.rw_n) && !pins.dq_out[0] |-> ##[1:8] !pins.out_en_n;
  endproperty
  a_array_off: assert property (p_array_off)
    else $error("array enable driven low");
  a_write_first: assert property (p_write_first)
    else $error("acquire did not write zero first");
  a_release_one: assert property (p_release_one)
    else $error("release did not write one");
  a_poll_gap: assert property (p_poll_gap)
    else $error("select held across reads");
  a_clean_bits: assert property (p_clean_bits)
    else $error("upper address or data bits set");
  a_no_clash: assert property (p_no_clash)
    else $error("read overlaps write");
  a_init: assert property (p_init)
    else $error("init not finished");
  a_read_len: assert property (p_read_len)
    else $error("read strobe length wrong");
  a_reinit: assert property (p_reinit)
    else $error("commanded init did not rerun");
  a_confirm: assert property (p_confirm)
    else $error("request write not followed by read");
endmodule // flag_port_ctrl_props

bind flag_port_ctrl flag_port_ctrl_props u_props (.mclk(mclk),
  .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd(cmd), .resp_valid(resp_valid), .resp(resp), .init_done(init_done),
  .pins(pins), .dq_in(dq_in));

// [dv/flag_port_ctrl_tb.sv]
// self-checking bench for the semaphore port controller
`timescale 1ns/1ps
module flag_port_ctrl_tb;
  import flag_port_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, r_we = 1'b0;
  logic r_bit = 1'b1, cmd_ready, resp_valid, init_done;
  logic [2:0] r_idx = 3'h0;
  logic [7:0] r_flag;
  logic [8:0] dq_in;
  flag_cmd_s cmd = '0;
  flag_resp_s resp, got;
  port_pins_s pins;
  int errors = 0, comparisons = 0;
  always #10 mclk = ~mclk;
  flag_port_ctrl uut (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .resp_valid(resp_valid), .resp(resp),
    .init_done(init_done), .pins(pins), .dq_in(dq_in));
  flag_ram_model ram (.pins(pins), .dq_in(dq_in), .r_we(r_we),
    .r_idx(r_idx), .r_bit(r_bit), .r_flag(r_flag));
  // ====
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  // granted only means something for acquire
  task automatic chk_resp(input flag_resp_s g, input flag_resp_s e);
    comparisons++;
    if (e.op != OP_ACQUIRE) begin
      e.granted = 1'b0;
      g.granted = 1'b0;
    end
    if (g !== e) fail($sformatf("reply %h, expected %h", g, e));
  endtask
  task automatic chk_flags(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) fail($sformatf("flags %h, expected %h", g, e));
  endtask
  task automatic wait_reply();
    for (int n = 0; n < 400; n++) begin
      @(negedge mclk);
      if (resp_valid === 1'b1) begin
        got = resp;
        return;
      end
    end
    fail("no reply");
    complete_run();
  endtask
  task automatic do_cmd(input flag_op_e op, input logic [2:0] idx);
    @(negedge mclk);
    cmd = {op, idx};
    cmd_valid = 1'b1;
    for (int n = 0; n < 400 && cmd_ready !== 1'b1; n++) @(negedge mclk);
    if (cmd_ready !== 1'b1) begin
      fail("command not taken");
      complete_run();
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
    wait_reply();
  endtask
  task automatic r_write(input logic [2:0] idx, input logic b);
    @(negedge mclk);
    r_idx = idx;
    r_bit = b;
    r_we = 1'b1;
    @(negedge mclk);
    r_we = 1'b0;
  endtask
  // ====
  task automatic t_init();
    wait_reply();
    chk_resp(got, {OP_INIT, 3'h7, 1'b1, 1'b0});
    chk_flags({7'h00, init_done}, 8'h01);
    chk_flags(r_flag, ~8'h3C);
    for (int i = 0; i < 8; i++) r_write(3'(i), 1'b1);
    chk_flags(r_flag, 8'hFF);
    $display("init test done");
  endtask
  task automatic t_grant();
    do_cmd(OP_ACQUIRE, 3'h5);
    chk_resp(got, {OP_ACQUIRE, 3'h5, 1'b0, 1'b1});
    chk_flags(r_flag, 8'hFF);
    r_write(3'h5, 1'b0);
    chk_flags(r_flag, 8'hFF);
    do_cmd(OP_READ, 3'h5);
    chk_resp(got, {OP_READ, 3'h5, 1'b0, 1'b0});
    $display("grant test done");
  endtask
  task automatic t_pass();
    do_cmd(OP_RELEASE, 3'h5);
    chk_resp(got, {OP_RELEASE, 3'h5, 1'b1, 1'b0});
    chk_flags(r_flag, 8'hDF);
    do_cmd(OP_READ, 3'h5);
    chk_resp(got, {OP_READ, 3'h5, 1'b1, 1'b0});
    $display("pass test done");
  endtask
  task automatic t_fail();
    do_cmd(OP_ACQUIRE, 3'h5);
    chk_resp(got, {OP_ACQUIRE, 3'h5, 1'b1, 1'b0});
    r_write(3'h5, 1'b1);
    do_cmd(OP_READ, 3'h5);
    chk_resp(got, {OP_READ, 3'h5, 1'b1, 1'b0});
    chk_flags(r_flag, 8'hFF);
    $display("fail test done");
  endtask
  task automatic t_index();
    do_cmd(OP_ACQUIRE, 3'h0);
    do_cmd(OP_ACQUIRE, 3'h7);
    chk_resp(got, {OP_ACQUIRE, 3'h7, 1'b0, 1'b1});
    r_write(3'h0, 1'b0);
    do_cmd(OP_RELEASE, 3'h0);
    chk_flags(r_flag, 8'hFE);
    do_cmd(OP_RELEASE, 3'h7);
    r_write(3'h0, 1'b1);
    chk_flags(r_flag, 8'hFF);
    $display("index test done");
  endtask
  // commanded init and a reset in mid-run must both free left-held flags
  task automatic t_restart();
    logic [7:0] idle;
    do_cmd(OP_ACQUIRE, 3'h2);
    do_cmd(OP_INIT, 3'h4);
    chk_resp(got, {OP_INIT, 3'h7, 1'b1, 1'b0});
    chk_flags({7'h00, init_done}, 8'h01);
    r_write(3'h2, 1'b0);
    chk_flags(r_flag, 8'hFB);
    r_write(3'h2, 1'b1);
    do_cmd(OP_ACQUIRE, 3'h3);
    chk_resp(got, {OP_ACQUIRE, 3'h3, 1'b0, 1'b1});
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    idle = {pins.flag_space_select_n, pins.array_en_n, pins.rw_n,
            pins.out_en_n, pins.dq_oe, init_done, cmd_ready, resp_valid};
    chk_flags(idle, 8'hF0);
    sys_rst = 1'b0;
    wait_reply();
    chk_resp(got, {OP_INIT, 3'h7, 1'b1, 1'b0});
    r_write(3'h3, 1'b0);
    chk_flags(r_flag, 8'hF7);
    r_write(3'h3, 1'b1);
    chk_flags(r_flag, 8'hFF);
    $display("restart test done");
  endtask
  // ====
  initial begin
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    t_init();
    t_grant();
    t_pass();
    t_fail();
    t_index();
    t_restart();
    complete_run();
  end
endmodule // flag_port_ctrl_tb
